// ---- verilog/ucc_uart_channel_command_status.sv ----
`timescale 1ns/1ps

// Operation
// - Channel B transmit clock: 1110 external 16X, 1111 external 1X on pin five.
// - Misc code 000 does nothing; 001 returns mode pointer to first register.
// - Code 010 resets and disables receiver, flushing FIFO; 011 resets transmitter.
// - Code 100 clears break, framing, parity and overrun bits together.
// - Code 101 clears that channel's break-change bit.
// - Start break drives line low after queued characters; needs transmitter enabled.
// - Stop break restores mark quickly, then two mark bits before next character.
// - Transmit disable clears ready and empty, finishing pending characters first.
// - Transmit enable starts the transmitter and sets transmit ready.
// - Receive disable stops at once, drops partial character, except multidrop mode.
// - Receive enable restarts start-bit search unless wake-up mode is active.
// - All-zero frame without stop is break; one entry; end after half-bit mark.
// - Framing error when stop bit is low at its middle.
// - Parity error on wrong parity; in multidrop holds the address/data bit.
// - Overrun when a char completes with FIFO full and one waiting.
// - Transmit empty set on underrun and enable; cleared by load, disable, reset.
// - Transmit ready means holding register empty; disabled loads are never sent.
// - FIFO full set at three entries; read clears it unless one waits.
// - Receive ready set on FIFO entry; cleared when a read empties FIFO.
// - Output pins five to seven: inverted port bit, or open-drain status.
module ucc_uart_channel_command_status
  import ucc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Serial lines and external clock.
  input wire logic serial_in_a_i,
  input wire logic serial_in_b_i,
  input wire logic input_pin_five_i,
  output logic serial_out_a_o,
  output logic serial_out_b_o,
  // Output port pins.
  output logic output_pin_seven_o,
  output logic output_pin_seven_oe_o,
  output logic output_pin_six_o,
  output logic output_pin_six_oe_o,
  output logic output_pin_five_o,
  output logic output_pin_five_oe_o
);

  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] ofs);
    return addr == {24'h000000, ofs};
  endfunction

  function automatic logic [7:0] chan_ofs(input int ch, input logic [7:0] ofs);
    return (ch == 0) ? ofs : ofs + CH_STRIDE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared registers and cross-channel signals.

  logic [7:0] clk_sel_b_q;
  logic [7:0] output_pin_config_q;
  logic [7:0] opr_q;
  logic [7:0] mode_q;
  logic [1:0] mr_ptr_q;
  logic [7:0] isr_w;
  logic [7:0] status_w [2];
  logic [7:0] rhr_w [2];
  logic cmd_wr_w [2];
  logic thr_wr_w [2];
  logic rhr_rd_w [2];
  logic transmit_holding_free_w [2];
  logic rx_char_available_w [2];
  logic brk_chg_q [2];
  logic tx_line_q [2];
  logic tx_tick16_w [2];
  logic tx_bit1x_w [2];
  logic ser_in_w [2];
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick16_q;
  logic ip5_s1_q;
  logic ip5_s2_q;
  logic ip5_s3_q;
  logic ext_rise_w;
  logic wr_q;
  logic [7:0] waddr_q;
  logic sel_ap_w;
  logic [31:0] rdata_d;

  assign ser_in_w[0] = serial_in_a_i;
  assign ser_in_w[1] = serial_in_b_i;
  assign serial_out_a_o = tx_line_q[0];
  assign serial_out_b_o = tx_line_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate ticks and external clock on pin five.

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || tick_cnt_q == TICK16_LAST) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
    tick16_q <= !sys_rst_i && tick_cnt_q == TICK16_LAST;
  end

  always_ff @(posedge clk_i) begin
    ip5_s1_q <= input_pin_five_i;
    ip5_s2_q <= ip5_s1_q;
    ip5_s3_q <= ip5_s2_q;
  end

  assign ext_rise_w = ip5_s2_q && !ip5_s3_q;

  // Channel A always uses the internal 16X tick.
  assign tx_tick16_w[0] = tick16_q;
  assign tx_bit1x_w[0] = 1'b0;
  assign tx_tick16_w[1] = (clk_sel_b_q[3:0] == CSB_EXT16) ? ext_rise_w :
                          (clk_sel_b_q[3:0] == CSB_EXT1) ? 1'b0 : tick16_q;
  assign tx_bit1x_w[1] = (clk_sel_b_q[3:0] == CSB_EXT1) && ext_rise_w;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave.

  assign sel_ap_w = hsel_i && hready_i && htrans_i[1];

  always_comb begin
    rdata_d = '0;
    for (int c = 0; c < 2; c++) begin
      if (reg_hit(haddr_i, chan_ofs(c, OFS_STATUS))) rdata_d[7:0] = status_w[c];
      if (reg_hit(haddr_i, chan_ofs(c, OFS_HOLDING))) rdata_d[7:0] = rhr_w[c];
    end
    if (reg_hit(haddr_i, OFS_CLK_SEL_B)) rdata_d[7:0] = clk_sel_b_q;
    if (reg_hit(haddr_i, OFS_OUTPUT_PIN_CONFIG)) rdata_d[7:0] = output_pin_config_q;
    if (reg_hit(haddr_i, OFS_OPR)) rdata_d[7:0] = opr_q;
    if (reg_hit(haddr_i, OFS_ISR)) rdata_d[7:0] = isr_w;
    if (reg_hit(haddr_i, OFS_MODE)) rdata_d[7:0] = mode_q;
    if (reg_hit(haddr_i, OFS_PTR)) rdata_d[1:0] = mr_ptr_q;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_q <= 1'b0;
      waddr_q <= '0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_q <= sel_ap_w && hwrite_i && haddr_i[31:8] == 24'h000000;
      waddr_q <= haddr_i[7:0];
      if (sel_ap_w && !hwrite_i) hrdata_o <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clk_sel_b_q <= RST_CLK_SEL_B;
      output_pin_config_q <= RST_OUTPUT_PIN_CONFIG;
      opr_q <= RST_OPR;
      mode_q <= RST_MODE;
    end else if (wr_q) begin
      if (waddr_q == OFS_CLK_SEL_B) clk_sel_b_q <= hwdata_i[7:0];
      if (waddr_q == OFS_OUTPUT_PIN_CONFIG) output_pin_config_q <= hwdata_i[7:0];
      if (waddr_q == OFS_OPR) opr_q <= hwdata_i[7:0];
      if (waddr_q == OFS_MODE) mode_q <= hwdata_i[7:0];
    end
  end

  always_comb begin
    isr_w = '0;
    isr_w[ISR_TRANSMIT_HOLDING_FREE_A] = transmit_holding_free_w[0];
    isr_w[ISR_RX_CHAR_AVAILABLE_A] = rx_char_available_w[0];
    isr_w[ISR_BRK_A] = brk_chg_q[0];
    isr_w[ISR_TRANSMIT_HOLDING_FREE_B] = transmit_holding_free_w[1];
    isr_w[ISR_RX_CHAR_AVAILABLE_B] = rx_char_available_w[1];
    isr_w[ISR_BRK_B] = brk_chg_q[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins: push-pull inverted port bit, or open drain pulled low on status.

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      output_pin_seven_o <= 1'b1;
      output_pin_seven_oe_o <= 1'b1;
      output_pin_six_o <= 1'b1;
      output_pin_six_oe_o <= 1'b1;
      output_pin_five_o <= 1'b1;
      output_pin_five_oe_o <= 1'b1;
    end else begin
      output_pin_seven_o <= output_pin_config_q[OUTPUT_PIN_CONFIG_PIN7] ? 1'b0 : !opr_q[OUTPUT_PIN_CONFIG_PIN7];
      output_pin_seven_oe_o <= !output_pin_config_q[OUTPUT_PIN_CONFIG_PIN7] || transmit_holding_free_w[1];
      output_pin_six_o <= output_pin_config_q[OUTPUT_PIN_CONFIG_PIN6] ? 1'b0 : !opr_q[OUTPUT_PIN_CONFIG_PIN6];
      output_pin_six_oe_o <= !output_pin_config_q[OUTPUT_PIN_CONFIG_PIN6] || transmit_holding_free_w[0];
      output_pin_five_o <= output_pin_config_q[OUTPUT_PIN_CONFIG_PIN5] ? 1'b0 : !opr_q[OUTPUT_PIN_CONFIG_PIN5];
      output_pin_five_oe_o <= !output_pin_config_q[OUTPUT_PIN_CONFIG_PIN5] || isr_w[ISR_RX_CHAR_AVAILABLE_B];
    end
  end

  // Mode pointer: a mode write moves it to the second register, command 001 back.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mr_ptr_q <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wr_q && waddr_q == OFS_MODE) mr_ptr_q[c] <= 1'b1;
        if (cmd_wr_w[c] && hwdata_i[6:4] == MISC_PTR) mr_ptr_q[c] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel transmitter and receiver.

  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic [3:0] md;
    logic [7:0] wd;
    ucc_misc_t misc;
    logic tx_en_q, tx_pend_q, thr_full_q, transmit_holding_free_q, transmit_underrun_flag_q, tx_busy_q;
    logic brk_req_q, brk_on_q;
    logic [1:0] mark_q;
    logic [7:0] thr_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_cnt_q, tx_sub_q;
    logic tx_bit_w;
    logic rx_en_q, rx_s1_q, rx_s2_q, rx_run_w, rx_par_w, rx_par_q;
    ucc_rx_state_t rx_st_q;
    logic [3:0] rx_sub_q, rx_cnt_q, hi_cnt_q;
    logic [7:0] rx_data_q;
    logic push_q, brk_evt_q;
    logic [10:0] push_word_q;
    logic [10:0] fifo_q [3];
    logic [10:0] fifo_d [3];
    logic [1:0] cnt_q, cnt_d;
    logic hold_v_q, hold_v_d, ovf_d;
    logic [10:0] hold_q, hold_d;
    logic [3:0] err_q;

    assign md = mode_q[4*g +: 4];
    assign wd = hwdata_i[7:0];
    assign misc = ucc_misc_t'(wd[6:4]);
    assign cmd_wr_w[g] = wr_q && waddr_q == chan_ofs(g, OFS_COMMAND);
    assign thr_wr_w[g] = wr_q && waddr_q == chan_ofs(g, OFS_HOLDING);
    assign rhr_rd_w[g] = sel_ap_w && !hwrite_i && reg_hit(haddr_i, chan_ofs(g, OFS_HOLDING));
    assign rhr_w[g] = fifo_q[0][7:0];
    assign transmit_holding_free_w[g] = transmit_holding_free_q;
    assign rx_char_available_w[g] = cnt_q != 2'h0;
    assign status_w[g] = {err_q, transmit_underrun_flag_q, transmit_holding_free_q, cnt_q == FIFO_FULL, cnt_q != 2'h0};
    assign tx_bit_w = tx_bit1x_w[g] || (tx_tick16_w[g] && tx_sub_q == SUB_LAST);

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) tx_sub_q <= '0;
      else if (tx_tick16_w[g]) tx_sub_q <= tx_sub_q + 1'b1;
    end

    // Transmitter.
    always_ff @(posedge clk_i) begin
      if (sys_rst_i || (cmd_wr_w[g] && misc == MISC_TX_RST)) begin
        tx_en_q <= 1'b0;
        tx_pend_q <= 1'b0;
        thr_full_q <= 1'b0;
        transmit_holding_free_q <= 1'b0;
        transmit_underrun_flag_q <= 1'b0;
        tx_busy_q <= 1'b0;
        tx_cnt_q <= '0;
        brk_req_q <= 1'b0;
        brk_on_q <= 1'b0;
        mark_q <= '0;
        thr_q <= '0;
        tx_sh_q <= '1;
        tx_line_q[g] <= 1'b1;
      end else begin
        if (tx_bit_w) begin
          if (tx_busy_q) begin
            if (tx_cnt_q != 4'h0) begin
              tx_line_q[g] <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_cnt_q <= tx_cnt_q - 1'b1;
            end else begin
              tx_busy_q <= 1'b0;
              if (!thr_full_q && tx_pend_q) tx_pend_q <= 1'b0;
              else if (!thr_full_q && tx_en_q) transmit_underrun_flag_q <= 1'b1;
            end
          end else if (brk_on_q) begin
            tx_line_q[g] <= 1'b0;
          end else if (mark_q != 2'h0) begin
            tx_line_q[g] <= 1'b1;
            mark_q <= mark_q - 1'b1;
          end else if (thr_full_q && (tx_en_q || tx_pend_q)) begin
            tx_sh_q <= {1'b1, (^thr_q) ^ md[MD_PAR_ODD], thr_q, 1'b0};
            if (!md[MD_PAR_EN]) tx_sh_q[9] <= 1'b1;
            tx_cnt_q <= md[MD_PAR_EN] ? 4'd11 : 4'd10;
            tx_busy_q <= 1'b1;
            thr_full_q <= 1'b0;
            transmit_holding_free_q <= tx_en_q;
          end else if (brk_req_q) begin
            brk_on_q <= 1'b1;
            brk_req_q <= 1'b0;
            tx_line_q[g] <= 1'b0;
          end else begin
            tx_line_q[g] <= 1'b1;
          end
        end
        if (cmd_wr_w[g]) begin
          if (wd[CMD_TX_DIS]) begin
            tx_en_q <= 1'b0;
            transmit_holding_free_q <= 1'b0;
            transmit_underrun_flag_q <= 1'b0;
            tx_pend_q <= tx_busy_q || thr_full_q;
          end
          if (wd[CMD_TX_EN]) begin
            tx_en_q <= 1'b1;
            transmit_holding_free_q <= 1'b1;
            tx_pend_q <= 1'b0;
            if (!tx_busy_q && !thr_full_q) transmit_underrun_flag_q <= 1'b1;
          end
          if (misc == MISC_BRK_START && tx_en_q) brk_req_q <= 1'b1;
          if (misc == MISC_BRK_STOP) begin
            brk_req_q <= 1'b0;
            if (brk_on_q) begin
              brk_on_q <= 1'b0;
              mark_q <= MARK_BITS;
              tx_line_q[g] <= 1'b1;
            end
          end
        end
        if (thr_wr_w[g] && tx_en_q) begin
          thr_q <= wd;
          thr_full_q <= 1'b1;
          transmit_holding_free_q <= 1'b0;
          transmit_underrun_flag_q <= 1'b0;
        end
      end
    end

    // Receiver enable and line synchroniser.
    always_ff @(posedge clk_i) begin
      rx_s1_q <= ser_in_w[g];
      rx_s2_q <= rx_s1_q;
      if (sys_rst_i || (cmd_wr_w[g] && misc == MISC_RX_RST)) rx_en_q <= 1'b0;
      else if (cmd_wr_w[g] && wd[CMD_RX_EN]) rx_en_q <= 1'b1;
      else if (cmd_wr_w[g] && wd[CMD_RX_DIS]) rx_en_q <= 1'b0;
    end

    assign rx_run_w = rx_en_q || md[MD_MULTIDROP];
    assign rx_par_w = md[MD_PAR_EN] || md[MD_MULTIDROP];

    // Receiver framing.
    always_ff @(posedge clk_i) begin
      push_q <= 1'b0;
      brk_evt_q <= 1'b0;
      if (sys_rst_i || (cmd_wr_w[g] && misc == MISC_RX_RST) || !rx_run_w) begin
        rx_st_q <= RX_IDLE;
        rx_sub_q <= '0;
        rx_cnt_q <= '0;
        hi_cnt_q <= '0;
        rx_data_q <= '0;
        rx_par_q <= 1'b0;
        push_word_q <= '0;
      end else if (cmd_wr_w[g] && wd[CMD_RX_EN] && !md[MD_WAKEUP]) begin
        rx_st_q <= RX_IDLE;
      end else if (tick16_q) begin
        case (rx_st_q)
          RX_IDLE: begin
            rx_sub_q <= '0;
            if (!rx_s2_q) rx_st_q <= RX_START;
          end
          RX_START: begin
            rx_sub_q <= rx_sub_q + 1'b1;
            if (rx_sub_q == SUB_MID) begin
              rx_sub_q <= '0;
              rx_cnt_q <= '0;
              rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            rx_sub_q <= rx_sub_q + 1'b1;
            if (rx_sub_q == SUB_LAST) begin
              rx_cnt_q <= rx_cnt_q + 1'b1;
              if (rx_cnt_q < 4'd8) begin
                rx_data_q <= {rx_s2_q, rx_data_q[7:1]};
              end else if (rx_cnt_q == 4'd8 && rx_par_w) begin
                rx_par_q <= rx_s2_q;
              end else begin
                push_q <= 1'b1;
                push_word_q[7:0] <= rx_data_q;
                push_word_q[9] <= !rx_s2_q;
                push_word_q[8] <= md[MD_MULTIDROP] ? rx_par_q :
                                  md[MD_PAR_EN] && ((^{rx_data_q, rx_par_q}) ^ md[MD_PAR_ODD]);
                push_word_q[10] <= 1'b0;
                rx_st_q <= RX_IDLE;
                if (!rx_s2_q && rx_data_q == 8'h00 && !(rx_par_w && rx_par_q)) begin
                  push_word_q[10] <= 1'b1;
                  brk_evt_q <= 1'b1;
                  hi_cnt_q <= '0;
                  rx_st_q <= RX_BRKW;
                end
              end
            end
          end
          RX_BRKW: begin
            hi_cnt_q <= rx_s2_q ? hi_cnt_q + 1'b1 : 4'h0;
            if (rx_s2_q && hi_cnt_q == HALF_BIT_LAST) begin
              brk_evt_q <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end

    // Receive FIFO with one waiting character behind it.
    always_comb begin
      fifo_d = fifo_q;
      cnt_d = cnt_q;
      hold_v_d = hold_v_q;
      hold_d = hold_q;
      ovf_d = 1'b0;
      if (rhr_rd_w[g] && cnt_d != 2'h0) begin
        fifo_d[0] = fifo_d[1];
        fifo_d[1] = fifo_d[2];
        cnt_d = cnt_d - 1'b1;
      end
      if (hold_v_d && cnt_d != FIFO_FULL) begin
        fifo_d[cnt_d] = hold_d;
        cnt_d = cnt_d + 1'b1;
        hold_v_d = 1'b0;
      end
      if (push_q) begin
        if (cnt_d != FIFO_FULL) begin
          fifo_d[cnt_d] = push_word_q;
          cnt_d = cnt_d + 1'b1;
        end else begin
          ovf_d = hold_v_d;
          hold_v_d = 1'b1;
          hold_d = push_word_q;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i || (cmd_wr_w[g] && misc == MISC_RX_RST)) begin
        cnt_q <= '0;
        hold_v_q <= 1'b0;
        hold_q <= '0;
        for (int i = 0; i < 3; i++) fifo_q[i] <= '0;
      end else begin
        cnt_q <= cnt_d;
        hold_v_q <= hold_v_d;
        hold_q <= hold_d;
        fifo_q <= fifo_d;
      end
    end

    // Sticky error bits and break change; a set in the clearing cycle wins.
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        err_q <= '0;
        brk_chg_q[g] <= 1'b0;
      end else begin
        if (cmd_wr_w[g] && misc == MISC_ERR_RST) err_q <= '0;
        if (push_q) err_q[3:1] <= push_word_q[10:8] |
            ((cmd_wr_w[g] && misc == MISC_ERR_RST) ? 3'h0 : err_q[3:1]);
        if (ovf_d) err_q[0] <= 1'b1;
        if (cmd_wr_w[g] && misc == MISC_BRK_CHG) brk_chg_q[g] <= 1'b0;
        if (brk_evt_q) brk_chg_q[g] <= 1'b1;
      end
    end
  end

endmodule

// ---- inc/ucc_pkg.sv ----
package ucc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TICK16_CYC = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
  localparam int unsigned TICK_W = 7;
  localparam logic [TICK_W-1:0] TICK16_LAST = TICK_W'(TICK16_CYC - 1);
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] HALF_BIT_LAST = 4'h7;
  localparam logic [1:0] MARK_BITS = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.

  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_HOLDING = 8'h08;
  localparam logic [7:0] OFS_CLK_SEL_B = 8'h30;
  localparam logic [7:0] OFS_OUTPUT_PIN_CONFIG = 8'h34;
  localparam logic [7:0] OFS_OPR = 8'h38;
  localparam logic [7:0] OFS_ISR = 8'h3C;
  localparam logic [7:0] OFS_MODE = 8'h40;
  localparam logic [7:0] OFS_PTR = 8'h44;

  localparam logic [7:0] RST_CLK_SEL_B = 8'h00;
  localparam logic [7:0] RST_OUTPUT_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_OPR = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts.

  localparam int unsigned CMD_TX_DIS = 3;
  localparam int unsigned CMD_TX_EN = 2;
  localparam int unsigned CMD_RX_DIS = 1;
  localparam int unsigned CMD_RX_EN = 0;

  typedef enum logic [2:0] {
    MISC_NONE = 3'h0,
    MISC_PTR = 3'h1,
    MISC_RX_RST = 3'h2,
    MISC_TX_RST = 3'h3,
    MISC_ERR_RST = 3'h4,
    MISC_BRK_CHG = 3'h5,
    MISC_BRK_START = 3'h6,
    MISC_BRK_STOP = 3'h7
  } ucc_misc_t;

  localparam logic [3:0] CSB_EXT16 = 4'hE;
  localparam logic [3:0] CSB_EXT1 = 4'hF;

  localparam int unsigned MD_PAR_EN = 0;
  localparam int unsigned MD_PAR_ODD = 1;
  localparam int unsigned MD_MULTIDROP = 2;
  localparam int unsigned MD_WAKEUP = 3;

  localparam int unsigned ISR_TRANSMIT_HOLDING_FREE_A = 0;
  localparam int unsigned ISR_RX_CHAR_AVAILABLE_A = 1;
  localparam int unsigned ISR_BRK_A = 2;
  localparam int unsigned ISR_TRANSMIT_HOLDING_FREE_B = 4;
  localparam int unsigned ISR_RX_CHAR_AVAILABLE_B = 5;
  localparam int unsigned ISR_BRK_B = 6;

  localparam int unsigned OUTPUT_PIN_CONFIG_PIN7 = 7;
  localparam int unsigned OUTPUT_PIN_CONFIG_PIN6 = 6;
  localparam int unsigned OUTPUT_PIN_CONFIG_PIN5 = 5;

  localparam logic [1:0] FIFO_FULL = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_BRKW = 4'b1000
  } ucc_rx_state_t;

endpackage

// ---- verif/ucc_serial_peer.sv ----
`timescale 1ns/1ps
module ucc_serial_peer
  import ucc_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Serial line toward the block, marking when idle.
  output logic line_o
);
  localparam int BIT_CYC = TICK16_CYC * OVERSAMPLE;

  initial line_o = 1'b1;

  // Sends one frame LSB first; a low stop bit makes a framing fault or, with zero data, a break.
  task automatic send(input logic [7:0] data, input logic stop);
    logic [9:0] frame;
    frame = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= frame[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask
endmodule

// ---- verif/ucc_sva.sv ----
`timescale 1ns/1ps
module ucc_sva
  import ucc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Lines and pins.
  input wire logic serial_out_a_o,
  input wire logic serial_out_b_o,
  input wire logic output_pin_seven_o,
  input wire logic output_pin_seven_oe_o,
  input wire logic output_pin_six_o,
  input wire logic output_pin_six_oe_o,
  input wire logic output_pin_five_o,
  input wire logic output_pin_five_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic take;
  logic rd;
  logic wr_q;
  logic [31:0] adr_q;
  assign take = hsel_i && hready_i && htrans_i[1];
  assign rd = take && !hwrite_i;
  always_ff @(posedge clk_i) begin
    wr_q <= take && hwrite_i && !sys_rst_i;
    adr_q <= haddr_i;
  end
  ////////////////////////////////////////////////////////////
  sequence s_stop_a;
    wr_q && adr_q == {24'h00_0000, OFS_COMMAND} && hwdata_i[6:4] == MISC_BRK_STOP;
  endsequence
  sequence s_mark_a;
    ##[1:2] serial_out_a_o ##1 serial_out_a_o [*8];
  endsequence
  a_ready_no_wait: assert property (hreadyout_o) else $error("hreadyout low");
  a_resp_always_okay: assert property (!hresp_o) else $error("hresp not OKAY");
  a_rdata_upper_zero: assert property (hrdata_o[31:8] == 24'h00_0000)
    else $error("hrdata upper bits set");
  a_rdata_holds_value: assert property (!rd |=> $stable(hrdata_o))
    else $error("hrdata changed without read");
  a_unmapped_reads_zero: assert property (rd && haddr_i[7:0] > OFS_PTR |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_idle_outputs: assert property ($fell(sys_rst_i) |-> serial_out_a_o && serial_out_b_o
    && output_pin_seven_o && output_pin_six_o && output_pin_five_o && hrdata_o == 32'h0)
    else $error("outputs not idle after reset");
  a_pins_open_drain: assert property ((output_pin_seven_oe_o || !output_pin_seven_o)
    && (output_pin_six_oe_o || !output_pin_six_o) && (output_pin_five_oe_o || !output_pin_five_o))
    else $error("released pin not low");
  a_stop_break_mark: assert property (s_stop_a |-> s_mark_a)
    else $error("line not marking after stop break");
endmodule

bind ucc_uart_channel_command_status ucc_sva u_sva (.clk_i, .sys_rst_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .serial_out_a_o, .serial_out_b_o, .output_pin_seven_o, .output_pin_seven_oe_o,
  .output_pin_six_o, .output_pin_six_oe_o, .output_pin_five_o, .output_pin_five_oe_o);

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  import ucc_pkg::*;
  logic clk_i, sys_rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, serial_in_a_i, input_pin_five_i;
  logic serial_out_a_o, serial_out_b_o, output_pin_seven_o, output_pin_seven_oe_o;
  logic output_pin_six_o, output_pin_six_oe_o, output_pin_five_o, output_pin_five_oe_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i;
  logic [5:0] pins;
  int n_fail = 0;
  int checked = 0;
  assign pins = {output_pin_seven_o, output_pin_seven_oe_o, output_pin_six_o,
    output_pin_six_oe_o, output_pin_five_o, output_pin_five_oe_o};
  ucc_uart_channel_command_status dut (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .serial_in_a_i, .serial_in_b_i(1'b1), .input_pin_five_i, .serial_out_a_o,
    .serial_out_b_o, .output_pin_seven_o, .output_pin_seven_oe_o, .output_pin_six_o,
    .output_pin_six_oe_o, .output_pin_five_o, .output_pin_five_oe_o);
  ucc_serial_peer peer (.clk_i, .line_o(serial_in_a_i));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [31:0] q);
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    htrans_i <= HTRANS_NONSEQ;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
    @(posedge clk_i);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(n, q & {24'hFF_FFFF, m}, {24'h00_0000, e});
  endtask
  task automatic line_is(input logic v);
    chk("line_a", {31'h0, serial_out_a_o}, {31'h0, v});
  endtask
  task automatic line_within(input logic v, input int lim);
    for (int i = 0; i < lim && serial_out_a_o !== v; i++) @(posedge clk_i);
    line_is(v);
  endtask
  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  initial begin
    {sys_rst_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = {3'b110, 2'h0, 64'h0};
    input_pin_five_i = 1'b0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    chk("pins", {26'h0, pins}, 32'h3F);
    rc("stat_a", OFS_STATUS, 8'hFF, 8'h00);
    rc("unmapped", 8'h80, 8'hFF, 8'h00);
    for (int i = 14; i < 16; i++) begin
      wr(OFS_CLK_SEL_B, 8'(i * 17));
      rc("csel_b", OFS_CLK_SEL_B, 8'hFF, 8'(i * 17));
    end
    wr(OFS_COMMAND + CH_STRIDE, 8'h04);
    wr(OFS_HOLDING + CH_STRIDE, 8'h00);
    repeat (3600) @(posedge clk_i);
    chk("line_b", {31'h0, serial_out_b_o}, 32'h1);
    repeat (4) begin
      input_pin_five_i <= ~input_pin_five_i;
      repeat (4) @(posedge clk_i);
    end
    chk("line_b", {31'h0, serial_out_b_o}, 32'h0);
    wr(OFS_MODE, 8'h00);
    rc("ptr", OFS_PTR, 8'h03, 8'h03);
    wr(OFS_COMMAND, 8'h10);
    wr(OFS_COMMAND, 8'h00);
    rc("ptr", OFS_PTR, 8'h03, 8'h02);
    wr(OFS_COMMAND, 8'h04);
    rc("stat_a", OFS_STATUS, 8'h0C, 8'h0C);
    wr(OFS_OUTPUT_PIN_CONFIG, 8'hE0);
    @(posedge clk_i);
    chk("pins", {26'h0, pins}, 32'h14);
    wr(OFS_OUTPUT_PIN_CONFIG, 8'h00);
    wr(OFS_OPR, 8'hA0);
    @(posedge clk_i);
    chk("pins", {26'h0, pins}, 32'h1D);
    wr(OFS_HOLDING, 8'h55);
    rc("stat_a", OFS_STATUS, 8'h08, 8'h00);
    line_within(1'b0, 4000);
    wr(OFS_COMMAND, 8'h08);
    rc("stat_a", OFS_STATUS, 8'h0C, 8'h00);
    line_is(1'b0);
    wr(OFS_COMMAND, 8'h30);
    wr(OFS_COMMAND, 8'h60);
    repeat (3500) @(posedge clk_i);
    line_is(1'b1);
    wr(OFS_COMMAND, 8'h04);
    wr(OFS_COMMAND, 8'h60);
    repeat (3500) @(posedge clk_i);
    line_is(1'b0);
    wr(OFS_COMMAND, 8'h70);
    repeat (4) @(posedge clk_i);
    line_is(1'b1);
    wr(OFS_COMMAND, 8'h01);
    peer.send(8'hA5, 1'b1);
    peer.send(8'h3C, 1'b0);
    rc("stat_a", OFS_STATUS, 8'hC3, 8'h41);
    rc("rx_a", OFS_HOLDING, 8'hFF, 8'hA5);
    rc("stat_a", OFS_STATUS, 8'h01, 8'h01);
    rc("rx_a", OFS_HOLDING, 8'hFF, 8'h3C);
    rc("stat_a", OFS_STATUS, 8'h01, 8'h00);
    wr(OFS_COMMAND, 8'h40);
    rc("stat_a", OFS_STATUS, 8'hF0, 8'h00);
    peer.send(8'h00, 1'b0);
    rc("stat_a", OFS_STATUS, 8'h81, 8'h81);
    rc("isr", OFS_ISR, 8'h04, 8'h04);
    wr(OFS_COMMAND, 8'h02);
    rc("stat_a", OFS_STATUS, 8'h81, 8'h81);
    wr(OFS_COMMAND, 8'h50);
    rc("isr", OFS_ISR, 8'h04, 8'h00);
    wr(OFS_COMMAND, 8'h20);
    rc("stat_a", OFS_STATUS, 8'h01, 8'h00);
    conclude();
  end
endmodule
